// file: rtl/mgs_motion_seq.sv
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module mgs_motion_seq
  import mgs_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [SPEED_W-1:0] motorSpeed,
  input wire logic mainCircuitOn,
  input wire logic servoAlarm,
  input wire logic brakeActive,
  input wire logic moveDone,
  input wire logic transCond,
  output logic moveStart,
  output logic [1:0] moveType,
  output logic [POS_W-1:0] moveTarget,
  output logic seqBusy,
  output logic [PIN_CNT-1:0] pinOutN
);
  // Main-circuit, alarm and transition pins cross in through two flops; brake is used directly
  logic [2:0] pinRaw;
  logic [2:0] pinSync;
  logic mainOnS;
  logic alarmS;
  logic transS;
  assign pinRaw = {transCond, servoAlarm, mainCircuitOn};
  mgs_sync #(.W(3)) u_sync (
    .clock(clock),
    .rst(rst),
    .din(pinRaw),
    .dout(pinSync)
  );
  assign mainOnS = pinSync[0];
  assign alarmS = pinSync[1];
  assign transS = pinSync[2];

  // Registers
  logic [DATA_W-1:0] ctrl_q;
  logic [SPEED_W-1:0] thresh_q;
  logic [DATA_W-1:0] pinMap_q;
  logic [DATA_W-1:0] grp_q [GRP_MAX];
  logic [POS_W-1:0] tgt_q [GRP_MAX];

  // Write channel
  logic [ADDR_W-1:0] awaddr_q;
  logic awHave_q;
  logic [DATA_W-1:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wHave_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arDone;
  logic wrFire;
  logic wrGrp;
  logic wrTgt;
  logic wrHit;
  logic [GRP_IDX_W-1:0] wrIdx;
  logic [DATA_W-1:0] wrMask;

  function automatic logic [DATA_W-1:0] strbMask(input logic [3:0] s);
    strbMask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : strbMask

  // Group window decode, shared by read and write paths
  function automatic logic inWin(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] base);
    inWin = (a[ADDR_W-1:8] == base[ADDR_W-1:8]) && (a[1:0] == 2'h0)
      && (a[7:2] < 6'(GRP_MAX));
  endfunction : inWin

  assign s_axi_awready = !awHave_q && !bvalid_q;
  assign s_axi_wready = !wHave_q && !bvalid_q;
  assign wrFire = awHave_q && wHave_q && !bvalid_q;
  assign wrIdx = awaddr_q[GRP_IDX_W+1:2];
  assign wrMask = strbMask(wstrb_q);
  assign wrGrp = inWin(awaddr_q, OFF_GRP_BASE);
  assign wrTgt = inWin(awaddr_q, OFF_TGT_BASE);
  assign wrHit = wrGrp || wrTgt || awaddr_q == OFF_CTRL
    || awaddr_q == OFF_THRESH || awaddr_q == OFF_PINMAP
    || awaddr_q == OFF_START || awaddr_q == OFF_STATUS;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready && bvalid_q) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  logic startWr;
  logic [GRP_IDX_W-1:0] startSel;
  assign startWr = wrFire && awaddr_q == OFF_START && wstrb_q[0];
  assign startSel = wdata_q[GRP_IDX_W-1:0];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
      thresh_q <= THRESH_RST;
      pinMap_q <= PINMAP_RST;
    end else if (wrFire) begin
      if (awaddr_q == OFF_CTRL)
        ctrl_q <= (ctrl_q & ~wrMask) | (wdata_q & wrMask);
      if (awaddr_q == OFF_THRESH)
        thresh_q <= (thresh_q & ~wrMask[SPEED_W-1:0])
          | (wdata_q[SPEED_W-1:0] & wrMask[SPEED_W-1:0]);
      if (awaddr_q == OFF_PINMAP)
        pinMap_q <= (pinMap_q & ~wrMask) | (wdata_q & wrMask);
    end
  end

  // Table storage: type, follow-on and target per entry
  genvar g;
  generate
    for (g = 0; g < GRP_MAX; g++) begin : g_tab
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          grp_q[g] <= '0;
          tgt_q[g] <= '0;
        end else if (wrFire && wrIdx == GRP_IDX_W'(g)) begin
          if (wrGrp)
            grp_q[g] <= (grp_q[g] & ~wrMask) | (wdata_q & wrMask);
          if (wrTgt)
            tgt_q[g] <= (tgt_q[g] & ~wrMask) | (wdata_q & wrMask);
        end
      end
    end
  endgenerate

  // Sequencer
  logic seqModeOn;
  logic chainMode;
  logic commCfg;
  logic [GRP_IDX_W-1:0] grpLimit;
  logic [GRP_IDX_W-1:0] cur_q;
  logic [GRP_IDX_W-1:0] nextIdx;
  logic [1:0] curType;
  logic curValid;
  logic selOk;
  logic nextOk;
  mgs_seq_e st_q;
  logic moveStart_q;
  logic [1:0] moveType_q;
  logic [POS_W-1:0] moveTarget_q;

  assign seqModeOn = ctrl_q[CTRL_MODE_LSB +: 4] == CTRL_MODE_SEQ;
  assign chainMode = ctrl_q[CTRL_SEQ_BIT];
  assign commCfg = ctrl_q[CTRL_COMM_BIT];
  // Parameter-mode table ends at entry 14; comm mode reaches 31
  assign grpLimit = commCfg ? GRP_IDX_W'(GRP_COMM_CNT - 1)
    : GRP_IDX_W'(GRP_PARAM_CNT - 1);
  assign selOk = startSel <= grpLimit;
  assign curType = grp_q[cur_q][GRP_TYPE_LSB +: 2];
  assign curValid = curType == TYPE_ABS || curType == TYPE_REL;
  assign nextIdx = grp_q[cur_q][GRP_NEXT_LSB +: GRP_IDX_W];
  assign nextOk = nextIdx <= grpLimit;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q <= SQ_IDLE;
      cur_q <= '0;
      moveStart_q <= 1'b0;
      moveType_q <= TYPE_INVALID;
      moveTarget_q <= '0;
    end else begin
      moveStart_q <= 1'b0;
      case (st_q)
        SQ_IDLE: begin
          if (startWr && seqModeOn && selOk) begin
            cur_q <= startSel;
            st_q <= SQ_RUN;
          end
        end
        SQ_RUN: begin
          if (!curValid) begin
            st_q <= SQ_IDLE;
          end else begin
            moveStart_q <= 1'b1;
            moveType_q <= curType;
            moveTarget_q <= tgt_q[cur_q];
            st_q <= SQ_WAIT;
          end
        end
        SQ_WAIT: begin
          // Chain waits here; a stuck transition holds the sequence
          if (!seqModeOn) begin
            st_q <= SQ_IDLE;
          end else if (moveDone) begin
            if (!chainMode) begin
              st_q <= SQ_IDLE;
            end else if (transS && nextOk) begin
              cur_q <= nextIdx;
              st_q <= SQ_RUN;
            end else if (!nextOk) begin
              st_q <= SQ_IDLE;
            end
          end
        end
        default: st_q <= SQ_IDLE;
      endcase
    end
  end
  assign moveStart = moveStart_q;
  assign moveType = moveType_q;
  assign moveTarget = moveTarget_q;
  assign seqBusy = st_q != SQ_IDLE;

  // Status outputs, active high internally, inverted at the terminals
  logic rotating;
  logic ready;
  logic [SRC_CNT-1:0] srcActive;
  assign rotating = motorSpeed > thresh_q;
  assign ready = mainOnS && !alarmS;
  assign srcActive = {alarmS, brakeActive, ready, rotating};

  mgs_pin_map u_pins (
    .clock(clock),
    .rst(rst),
    .srcActive(srcActive),
    .pinMap(pinMap_q[PIN_CNT*SRC_CNT-1:0]),
    .pinOutN(pinOutN)
  );

  // Read channel
  logic arHave_q;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0] rresp_q;
  logic rdGrp;
  logic rdTgt;
  logic [GRP_IDX_W-1:0] rdIdx;
  logic [DATA_W-1:0] rdMux;
  logic rdHit;
  assign s_axi_arready = !arHave_q;
  assign arDone = s_axi_arvalid && s_axi_arready;
  assign rdIdx = s_axi_araddr[GRP_IDX_W+1:2];
  assign rdGrp = inWin(s_axi_araddr, OFF_GRP_BASE);
  assign rdTgt = inWin(s_axi_araddr, OFF_TGT_BASE);
  assign rdHit = rdGrp || rdTgt || s_axi_araddr == OFF_CTRL
    || s_axi_araddr == OFF_THRESH || s_axi_araddr == OFF_PINMAP
    || s_axi_araddr == OFF_STATUS || s_axi_araddr == OFF_START;
  assign rdMux =
    rdGrp ? grp_q[rdIdx] :
    rdTgt ? tgt_q[rdIdx] :
    s_axi_araddr == OFF_CTRL ? ctrl_q :
    s_axi_araddr == OFF_THRESH ? {16'h0000, thresh_q} :
    s_axi_araddr == OFF_PINMAP ? pinMap_q :
    s_axi_araddr == OFF_STATUS ? {16'h0000, ~pinOutN, 1'b0, ready,
      rotating, seqBusy, 3'h0, cur_q} :
    32'h0000_0000;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      arHave_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (arDone) begin
      arHave_q <= 1'b1;
      rdata_q <= rdMux;
      rresp_q <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      arHave_q <= 1'b0;
    end
  end
  assign s_axi_rvalid = arHave_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Checks
  // Rotation checked at the terminal, not on the compare itself
  a_rot_detect: assert property (@(posedge clock) disable iff (rst)
    (motorSpeed > thresh_q && pinMap_q[SRC_ROT]) |=> !pinOutN[0])
    else $error("rotation not flagged above threshold");
  a_rot_stopped: assert property (@(posedge clock) disable iff (rst)
    (motorSpeed <= thresh_q && pinMap_q[3:0] == 4'h1) |=> pinOutN[0])
    else $error("rotation flagged while stopped");
  a_rdy_needs: assert property (@(posedge clock) disable iff (rst)
    ready |-> $past(mainCircuitOn, 2) && !$past(servoAlarm, 2))
    else $error("ready without main power or with alarm");
  a_rdy_drops: assert property (@(posedge clock) disable iff (rst)
    $past(servoAlarm, 2) |-> !ready)
    else $error("ready with alarm present");
  a_grp_limit: assert property (@(posedge clock) disable iff (rst)
    (st_q == SQ_IDLE && startWr && !commCfg && startSel > 5'hE)
    |=> !seqBusy)
    else $error("start beyond table accepted");
  a_single_stop: assert property (@(posedge clock) disable iff (rst)
    (st_q == SQ_WAIT && moveDone && !chainMode) |=> !seqBusy ##1
    !moveStart)
    else $error("single start continued");
  a_seq_first: assert property (@(posedge clock) disable iff (rst)
    (st_q == SQ_IDLE && startWr && seqModeOn && selOk)
    |=> cur_q == $past(startSel))
    else $error("sequence did not start at selection");
  a_seq_next: assert property (@(posedge clock) disable iff (rst)
    (st_q == SQ_WAIT && moveDone && chainMode && transS && nextOk
     && seqModeOn) |=> st_q == SQ_RUN && cur_q == $past(nextIdx))
    else $error("follow-on not launched");
  a_mode_gate: assert property (@(posedge clock) disable iff (rst)
    (startWr && !seqModeOn && st_q == SQ_IDLE) |=> !seqBusy)
    else $error("start outside sequence mode");
  a_invalid_idle: assert property (@(posedge clock) disable iff (rst)
    (st_q == SQ_RUN && !curValid) |=> !moveStart && !seqBusy)
    else $error("invalid group moved");
  c_single: cover property (@(posedge clock) disable iff (rst)
    moveStart && !chainMode);
  c_chain: cover property (@(posedge clock) disable iff (rst)
    st_q == SQ_WAIT && moveDone && chainMode && transS);
  c_invalid: cover property (@(posedge clock) disable iff (rst)
    st_q == SQ_RUN && !curValid);
endmodule : mgs_motion_seq

// file: pkg/mgs_pkg.sv
package mgs_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 12;
  localparam int GRP_IDX_W = 5;
  localparam int GRP_PARAM_CNT = 15;
  localparam int GRP_COMM_CNT = 32;
  localparam int GRP_MAX = 32;
  localparam int SPEED_W = 16;
  localparam int POS_W = 32;
  localparam int PIN_CNT = 4;
  localparam int SRC_CNT = 4;

  // Group type codes
  localparam logic [1:0] TYPE_INVALID = 2'h0;
  localparam logic [1:0] TYPE_ABS = 2'h1;
  localparam logic [1:0] TYPE_REL = 2'h2;

  // Control mode digit value for motion sequence operation
  localparam logic [3:0] CTRL_MODE_SEQ = 4'hC;

  // Status source indices for pin mapping
  localparam int SRC_ROT = 0;
  localparam int SRC_RDY = 1;
  localparam int SRC_BRK = 2;
  localparam int SRC_ALM = 3;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_THRESH = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_PINMAP = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_START = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_GRP_BASE = 12'h100;
  localparam logic [ADDR_W-1:0] OFF_TGT_BASE = 12'h200;

  // CTRL fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SEQ_BIT = 4;
  localparam int CTRL_COMM_BIT = 5;

  // Group entry fields
  localparam int GRP_TYPE_LSB = 0;
  localparam int GRP_NEXT_LSB = 8;
  localparam int GRP_TRANS_BIT = 16;

  // Reset values
  localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;
  localparam logic [SPEED_W-1:0] THRESH_RST = 16'h0014;
  localparam logic [DATA_W-1:0] PINMAP_RST = 32'h0000_8421;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SQ_IDLE = 2'h0,
    SQ_RUN = 2'h1,
    SQ_WAIT = 2'h2
  } mgs_seq_e;
endpackage : mgs_pkg

// file: rtl/mgs_sync.sv
`timescale 1ns/1ps
module mgs_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage feeds only the second
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule : mgs_sync

// file: rtl/mgs_pin_map.sv
`timescale 1ns/1ps
module mgs_pin_map
  import mgs_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [SRC_CNT-1:0] srcActive,
  input wire logic [PIN_CNT*SRC_CNT-1:0] pinMap,
  output logic [PIN_CNT-1:0] pinOutN
);
  logic [PIN_CNT-1:0] pinOutNQ;
  logic [PIN_CNT-1:0] pinActive;

  genvar p;
  generate
    for (p = 0; p < PIN_CNT; p++) begin : g_pin
      // Several sources on one terminal combine as OR
      assign pinActive[p] =
        |(srcActive & pinMap[p*SRC_CNT +: SRC_CNT]);
    end
  endgenerate

  // Registered, active-low terminals; idle high after reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pinOutNQ <= '1;
    end else begin
      pinOutNQ <= ~pinActive;
    end
  end

  assign pinOutN = pinOutNQ;

  // Skip the edge after reset: the flops were held, not loaded
  a_pin_or_map: assert property (@(posedge clock) disable iff (rst)
    !$past(rst) |-> pinOutN == ~$past(pinActive))
    else $error("pin not OR of mapped sources");
endmodule : mgs_pin_map

// file: verif/mgs_far_model.sv
`timescale 1ns/1ps
module mgs_far_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic moveStart,
  input wire logic slow,
  input wire logic condOk,
  output logic moveDone,
  output logic transCond
);
  int cnt;
  // Done only follows a launched move, never on its own
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      moveDone <= 1'b0;
    end else begin
      moveDone <= (cnt == 1);
      if (moveStart) begin
        cnt <= slow ? 12 : 2;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
  assign transCond = condOk;
endmodule : mgs_far_model

// file: verif/testbench.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("unexpected at %0t: %h vs %h", $time, (got), (exp)); \
    end \
  end
module testbench;
  import mgs_pkg::*;
  logic clock, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, mainCircuitOn;
  logic servoAlarm, brakeActive, moveDone, transCond, moveStart;
  logic seqBusy, slow, condOk;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, moveType, eb;
  logic [SPEED_W-1:0] motorSpeed;
  logic [POS_W-1:0] moveTarget;
  logic [PIN_CNT-1:0] pinOutN;
  logic [33:0] er, em;
  logic [1:0] bQ[$];
  logic [33:0] rQ[$], mQ[$];
  logic [1:0] tp[32];
  logic [31:0] tgt[32];
  logic [31:0] seed = 32'hB38FE38B;
  int errors = 0, checked = 0, cycles = 0;

  mgs_motion_seq mgs_motion_seq_i (.clock, .rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .motorSpeed, .mainCircuitOn, .servoAlarm, .brakeActive, .moveDone,
    .transCond, .moveStart, .moveType, .moveTarget, .seqBusy, .pinOutN);
  mgs_far_model mgs_far_model_i (.clock, .rst, .moveStart, .slow,
    .condOk, .moveDone, .transCond);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic end_of_test;
    if (errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
      input logic [1:0] r);
    bit aw, w;
    bQ.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    aw = 0;
    w = 0;
    while (!(aw && w)) begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) aw = 1;
      if (s_axi_wvalid && s_axi_wready) w = 1;
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clock);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] d,
      input logic [1:0] r);
    rQ.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    @(posedge clock);
    while (s_axi_arready !== 1'b1) @(posedge clock);
    s_axi_arvalid <= 1'b0;
    @(posedge clock);
    while (s_axi_rvalid !== 1'b1) @(posedge clock);
  endtask : rd

  task automatic settle;
    repeat (5) @(posedge clock);
  endtask : settle

  task automatic grp(input int g, input logic [1:0] t, input int nx);
    seed = lfsr(seed);
    tp[g] = t;
    tgt[g] = seed;
    wr(OFF_GRP_BASE + 12'(4 * g), {19'h0, 5'(nx), 6'h0, t}, RESP_OKAY);
    wr(OFF_TGT_BASE + 12'(4 * g), seed, RESP_OKAY);
  endtask : grp

  // Trailing idle cycles let a stray launch reach the monitor
  task automatic go(input int g, input bit launch);
    if (launch) mQ.push_back({tp[g], tgt[g]});
    wr(OFF_START, 32'(g), RESP_OKAY);
    repeat (2) @(posedge clock);
    while (seqBusy !== 1'b0) @(posedge clock);
    repeat (20) @(posedge clock);
  endtask : go

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_of_test();
    end
  end

  // Empty queue yields an unknown note, so a stray result fails
  always @(posedge clock) begin
    if (s_axi_bvalid === 1'b1) begin
      eb = bQ.size() ? bQ.pop_front() : 2'bxx;
      `CHK(s_axi_bresp, eb)
    end
    if (s_axi_rvalid === 1'b1) begin
      er = rQ.size() ? rQ.pop_front() : 34'bx;
      `CHK({s_axi_rresp, s_axi_rdata}, er)
    end
    if (moveStart === 1'b1) begin
      em = mQ.size() ? mQ.pop_front() : 34'bx;
      `CHK({moveType, moveTarget}, em)
    end
  end

  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_araddr, s_axi_arvalid, motorSpeed, mainCircuitOn} = '0;
    {servoAlarm, brakeActive, slow, condOk} = '0;
    // Ready lines held high; AXI allows it and it keeps drivers simple
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    s_axi_wstrb = 4'hF;
    rst = 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(OFF_CTRL, CTRL_RST, RESP_OKAY);
    rd(OFF_THRESH, 32'(THRESH_RST), RESP_OKAY);
    rd(OFF_PINMAP, PINMAP_RST, RESP_OKAY);
    rd(12'hFF0, 32'h0, RESP_SLVERR);
    wr(12'hFF0, 32'h1, RESP_SLVERR);
    s_axi_wstrb <= 4'h1;
    wr(OFF_THRESH, 32'h0000_AB77, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(OFF_THRESH, 32'h0000_0077, RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      wr(OFF_THRESH, {17'h0, seed[14:0]}, RESP_OKAY);
      motorSpeed <= {1'b0, seed[14:0]} + 16'h1;
      settle();
      `CHK(pinOutN[0], 1'b0)
      motorSpeed <= {1'b0, seed[14:0]};
      settle();
      `CHK(pinOutN[0], 1'b1)
    end
    motorSpeed <= 16'h0;
    for (int i = 0; i < 4; i++) begin
      mainCircuitOn <= i[0];
      servoAlarm <= i[1];
      settle();
      `CHK(pinOutN[1], !(i[0] && !i[1]))
    end
    servoAlarm <= 1'b0;
    wr(OFF_PINMAP, 32'h0000_8425, RESP_OKAY);
    brakeActive <= 1'b1;
    settle();
    `CHK(pinOutN, 4'b1000)
    brakeActive <= 1'b0;
    settle();
    `CHK(pinOutN, 4'b1101)
    grp(0, TYPE_ABS, 1);
    grp(1, TYPE_REL, 2);
    grp(2, TYPE_ABS, 3);
    grp(3, TYPE_INVALID, 0);
    grp(14, TYPE_REL, 0);
    grp(15, TYPE_ABS, 0);
    grp(31, TYPE_REL, 0);
    rd(OFF_GRP_BASE + 12'h4, {19'h0, 5'h2, 6'h0, TYPE_REL}, RESP_OKAY);
    go(0, 0);
    wr(OFF_CTRL, 32'h0000_000C, RESP_OKAY);
    slow <= 1'b1;
    go(2, 1);
    go(1, 1);
    slow <= 1'b0;
    go(3, 0);
    go(15, 0);
    go(14, 1);
    wr(OFF_CTRL, 32'h0000_002C, RESP_OKAY);
    go(31, 1);
    wr(OFF_CTRL, 32'h0000_001C, RESP_OKAY);
    condOk <= 1'b1;
    for (int g = 0; g < 3; g++) mQ.push_back({tp[g], tgt[g]});
    go(0, 0);
    condOk <= 1'b0;
    mQ.push_back({tp[1], tgt[1]});
    wr(OFF_START, 32'h1, RESP_OKAY);
    repeat (40) @(posedge clock);
    `CHK(seqBusy, 1'b1)
    rd(OFF_STATUS, 32'h0000_2501, RESP_OKAY);
    wr(OFF_CTRL, 32'h0, RESP_OKAY);
    settle();
    `CHK(seqBusy, 1'b0)
    `CHK(mQ.size() + bQ.size() + rQ.size(), 0)
    end_of_test();
  end
endmodule : testbench
